// File: hw/bsi_boot_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsi_regs.svh"
module bsi_boot_select #(
    parameter logic [3:0]  VERSION_ID = 4'h7,     // Value is arbitrary.
    parameter logic [15:0] PART_ID    = 16'h1234, // Value is arbitrary.
    parameter logic [10:0] MAKER_ID   = 11'h0AA   // Value is arbitrary.
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        boot_memory_select_in,
    input  wire logic [7:0]  boot_order_config_in,
    input  wire logic [7:0]  ref_clk_mhz_in,
    input  wire logic        ref_valid_in,
    input  wire logic        try_fail_in,
    input  wire logic        try_ok_in,
    output logic [31:0]      boundary_scan_identity_out,
    output logic             rom_at_zero_out,
    output logic [31:0]      fetch_addr_out,
    output logic             static_timing_default_out,
    output logic [7:0]       processor_clock_mhz_out,
    output logic [7:0]       master_clock_mhz_out,
    output logic             usb_monitor_en_out,
    output logic [5:0]       src_enable_out,
    output logic [2:0]       src_try_out,
    output logic             src_active_out
);
    // ------------------------------------------------------------
    // Reset capture.
    // ------------------------------------------------------------
    logic first_q, first_d, rom_q, rom_d;
    always_comb begin
        first_d = 1'h0;
        rom_d   = first_q ? boot_memory_select_in : rom_q;
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            first_q <= 1'h1;
            rom_q   <= 1'h0;
        end else begin
            first_q <= first_d;
            rom_q   <= rom_d;
        end
    end
    // ------------------------------------------------------------
    // Identity, map and clocks.
    // ------------------------------------------------------------
    bsi_pkg::bsi_ident_s id_d;
    bsi_pkg::bsi_clk_s   clk_d;
    logic [5:0]          mask_d;
    logic                ref_ok;
    always_comb begin
        id_d = '{version: VERSION_ID, part: PART_ID, maker: MAKER_ID, one: `BSI_ID_BIT0};
        ref_ok = ref_valid_in && ref_clk_mhz_in >= `BSI_REF_LO_MHZ && ref_clk_mhz_in <= `BSI_REF_HI_MHZ;
        clk_d = '{proc_mhz: `BSI_RC_MHZ, master_mhz: `BSI_RC_MHZ, usb_en: 1'h0};
        if (rom_q && !first_q && ref_ok) begin
            clk_d = '{proc_mhz: `BSI_PROC_MHZ, master_mhz: `BSI_MASTER_MHZ, usb_en: 1'h1};
        end
        case (boot_order_config_in[`BSI_ORDER_BITS])
            3'h0:    mask_d = `BSI_MASK_ALL;
            3'h1:    mask_d = `BSI_MASK_NO_SD;
            3'h2:    mask_d = `BSI_MASK_NO_SDNAND;
            3'h3:    mask_d = `BSI_MASK_NO_SDNAND;
            3'h4:    mask_d = `BSI_MASK_THREE;
            default: mask_d = `BSI_MASK_MON;
        endcase
    end
    // ------------------------------------------------------------
    // Source sequencer.
    // ------------------------------------------------------------
    bsi_pkg::bsi_state_e st_q, st_d;
    logic [2:0]          try_q, try_d, nxt;
    logic                found;
    logic [5:0]          later_en;
    // Marks every enabled source that stands after the one being tried.
    for (genvar g = 0; g < `BSI_SRC_NUM; g++) begin : g_later
        assign later_en[g] = mask_d[g] && (3'(g) > try_q);
    end
    always_comb begin
        nxt   = `BSI_SRC_MON;
        found = 1'h0;
        for (int i = 0; i < `BSI_SRC_NUM; i++) begin
            if (!found && later_en[i]) begin
                nxt   = 3'(i);
                found = 1'h1;
            end
        end
        st_d  = st_q;
        try_d = try_q;
        case (st_q)
            bsi_pkg::BSI_IDLE: begin
                if (!first_q && rom_q) begin
                    st_d  = bsi_pkg::BSI_TRY;
                    try_d = mask_d[0] ? `BSI_SRC_FIRST : nxt;
                end
            end
            bsi_pkg::BSI_TRY: begin
                if (try_ok_in || try_q == `BSI_SRC_MON) begin
                    st_d = bsi_pkg::BSI_DONE;
                end else if (try_fail_in) begin
                    try_d = nxt;
                end
            end
            bsi_pkg::BSI_DONE: st_d = st_q;
            default: st_d = bsi_pkg::BSI_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Output staging.
    // ------------------------------------------------------------
    logic [31:0] ident_d;
    logic        timing_dflt_d;
    logic        active_d;
    always_comb begin
        ident_d       = id_d;
        timing_dflt_d = !rom_d;
        active_d      = (st_d == bsi_pkg::BSI_TRY);
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q                       <= bsi_pkg::BSI_IDLE;
            try_q                      <= `BSI_SRC_FIRST;
            boundary_scan_identity_out <= `BSI_ID_RESET;
            rom_at_zero_out            <= 1'h0;
            fetch_addr_out             <= `BSI_BOOT_ADDR;
            static_timing_default_out  <= 1'h1;
            processor_clock_mhz_out    <= `BSI_RC_MHZ;
            master_clock_mhz_out       <= `BSI_RC_MHZ;
            usb_monitor_en_out         <= 1'h0;
            src_enable_out             <= `BSI_MASK_ALL;
            src_try_out                <= `BSI_SRC_FIRST;
            src_active_out             <= 1'h0;
        end else begin
            st_q                       <= st_d;
            try_q                      <= try_d;
            boundary_scan_identity_out <= ident_d;
            rom_at_zero_out            <= rom_d;
            fetch_addr_out             <= `BSI_BOOT_ADDR;
            static_timing_default_out  <= timing_dflt_d;
            processor_clock_mhz_out    <= clk_d.proc_mhz;
            master_clock_mhz_out       <= clk_d.master_mhz;
            usb_monitor_en_out         <= clk_d.usb_en;
            src_enable_out             <= mask_d;
            src_try_out                <= try_d;
            src_active_out             <= active_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    AST_ID_BIT0: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        boundary_scan_identity_out[0])
        else $error("id bit0 low");
    AST_ID_FIELDS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !first_q |-> boundary_scan_identity_out[31:1] == {VERSION_ID, PART_ID, MAKER_ID})
        else $error("id fields");
    AST_ADDR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        fetch_addr_out == `BSI_BOOT_ADDR)
        else $error("fetch addr");
    AST_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !first_q && !$past(first_q) |-> $stable(rom_at_zero_out))
        else $error("map changed");
    AST_MAP_CAPTURE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        first_q |=> rom_at_zero_out == $past(boot_memory_select_in))
        else $error("map not captured");
    AST_EXT_MAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        first_q && !boot_memory_select_in |=> !rom_at_zero_out && static_timing_default_out)
        else $error("ext map");
    AST_EXT_TIMING: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !first_q && !rom_at_zero_out |-> static_timing_default_out && processor_clock_mhz_out == `BSI_RC_MHZ)
        else $error("ext boot");
    AST_EXT_CLOCKS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !first_q && !rom_at_zero_out |-> master_clock_mhz_out == `BSI_RC_MHZ && !usb_monitor_en_out)
        else $error("ext clocks");
    AST_ROM_MAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rom_at_zero_out |-> !static_timing_default_out)
        else $error("rom map");
    AST_ROM_START: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        first_q |=> processor_clock_mhz_out == `BSI_RC_MHZ && master_clock_mhz_out == `BSI_RC_MHZ)
        else $error("start clocks");
    AST_USB: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        usb_monitor_en_out |-> master_clock_mhz_out == `BSI_MASTER_MHZ && processor_clock_mhz_out == `BSI_PROC_MHZ)
        else $error("pll");
    AST_USB_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!ref_valid_in || ref_clk_mhz_in < `BSI_REF_LO_MHZ || ref_clk_mhz_in > `BSI_REF_HI_MHZ)
        |=> !usb_monitor_en_out)
        else $error("usb without reference");
    AST_ORDER_ALL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        boot_order_config_in[`BSI_ORDER_BITS] == 3'h0 |=> src_enable_out == `BSI_MASK_ALL)
        else $error("order all");
    AST_ORDER_NO_SD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        boot_order_config_in[`BSI_ORDER_BITS] == 3'h1 |=> src_enable_out == `BSI_MASK_NO_SD)
        else $error("order no sd");
    AST_ORDER_MID: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (boot_order_config_in[`BSI_ORDER_BITS] == 3'h2 || boot_order_config_in[`BSI_ORDER_BITS] == 3'h3)
        |=> src_enable_out == `BSI_MASK_NO_SDNAND)
        else $error("order mid");
    AST_ORDER_THREE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        boot_order_config_in[`BSI_ORDER_BITS] == 3'h4 |=> src_enable_out == `BSI_MASK_THREE)
        else $error("order three");
    AST_MON_ONLY: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        boot_order_config_in[`BSI_ORDER_BITS] > 3'h4 |=> src_enable_out == `BSI_MASK_MON)
        else $error("mask");
    AST_TRY_EN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        src_active_out |-> src_enable_out[src_try_out] || src_try_out == `BSI_SRC_MON)
        else $error("try");
    AST_ADVANCE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        src_active_out && try_fail_in && !try_ok_in && src_try_out != `BSI_SRC_MON
        |=> src_try_out > $past(src_try_out))
        else $error("no advance");
    AST_MON_END: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        src_active_out && src_try_out == `BSI_SRC_MON |=> !src_active_out)
        else $error("monitor not last");

    // ------------------------------------------------------------
    // Cover points.
    // ------------------------------------------------------------
    COV_ROM: cover property (@(posedge clk_in) rom_at_zero_out && src_active_out);
    COV_EXT: cover property (@(posedge clk_in) !first_q && !rom_at_zero_out);
    COV_FAIL: cover property (@(posedge clk_in) src_active_out && try_fail_in);
    COV_USB: cover property (@(posedge clk_in) usb_monitor_en_out);
    COV_MON: cover property (@(posedge clk_in) src_active_out && src_try_out == `BSI_SRC_MON);
endmodule : bsi_boot_select
`default_nettype wire

// File: hw/bsi_pkg.sv
package bsi_pkg;
    typedef enum logic [1:0] {BSI_IDLE, BSI_TRY, BSI_DONE} bsi_state_e;
    typedef struct packed {
        logic [3:0]  version;
        logic [15:0] part;
        logic [10:0] maker;
        logic        one;
    } bsi_ident_s;
    typedef struct packed {
        logic [7:0] proc_mhz;
        logic [7:0] master_mhz;
        logic       usb_en;
    } bsi_clk_s;
endpackage : bsi_pkg

// File: hw/bsi_regs.svh
// Contract
// - Read-only identity: version, part, maker fields.
// - Identity bit zero always reads one.
// - Fetch always starts at address zero.
// - Select pin sampled at reset, held.
// - Select low maps external chip select zero.
// - Select high maps embedded ROM.
// - External boot: reset values, 12 MHz RC.
// - External boot: default static timing on select zero.
// - ROM boot starts both clocks on RC.
// - Only three low order bits steer.
// - Order 0 all sources; 1 drops SD.
// - 2,3 drop SD/NAND; 4 keeps three; 5-7 monitor.
// - ROM boot PLL: 96 and 48 MHz.
// - 4-28 MHz reference treated 12; enables USB.
`ifndef BSI_REGS_SVH
`define BSI_REGS_SVH
`define BSI_BOOT_ADDR      32'h0000_0000
`define BSI_ID_RESET       32'h0000_0001
`define BSI_ID_BIT0        1'h1
`define BSI_RC_MHZ         8'h0C
`define BSI_PROC_MHZ       8'h60
`define BSI_MASTER_MHZ     8'h30
`define BSI_REF_LO_MHZ     8'h04
`define BSI_REF_HI_MHZ     8'h1C
`define BSI_SRC_NUM        3'h6
`define BSI_SRC_MON        3'h5
`define BSI_SRC_FIRST      3'h0
`define BSI_ORDER_BITS     2:0
`define BSI_MASK_ALL       6'h3F
`define BSI_MASK_NO_SD     6'h3D
`define BSI_MASK_NO_SDNAND 6'h39
`define BSI_MASK_THREE     6'h31
`define BSI_MASK_MON       6'h20
`endif

// File: tb/bsi_boot_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bsi_boot_partner (
    input  wire logic clk_in,
    input  wire logic active_in,
    input  wire logic fail_req_in,
    input  wire logic ok_req_in,
    output logic      try_fail_out,
    output logic      try_ok_out
);
    // Boot software reports an outcome only while a source is tried.
    always_ff @(posedge clk_in) begin
        try_fail_out <= fail_req_in & active_in;
        try_ok_out   <= ok_req_in & active_in;
    end
endmodule : bsi_boot_partner
`default_nettype wire

// File: tb/bsi_boot_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bsi_boot_select_bench;
    logic clk = 0, rst = 1, sel = 1, rv = 1, fr = 0, kr = 0;
    logic tf, tk, rom, tmg, usb, act;
    logic [7:0] cfg = 8'h00, rf = 8'h0C, pmhz, mmhz;
    logic [31:0] id, adr;
    logic [5:0] en;
    logic [2:0] tr;
    int fail_count = 0, compares = 0, cyc = 0;
    localparam logic [31:0] ID = {4'h3, 16'hA5C3, 11'h155, 1'h1};
    localparam logic [5:0] MK [8] = '{6'h3F, 6'h3D, 6'h39, 6'h39, 6'h31, 6'h20, 6'h20, 6'h20};
    always #4 clk = ~clk;
    // Identity values are arbitrary.
    bsi_boot_select #(.VERSION_ID(4'h3), .PART_ID(16'hA5C3), .MAKER_ID(11'h155)) bsi_boot_select_i (
        .clk_in(clk), .sys_rst_in(rst), .boot_memory_select_in(sel), .boot_order_config_in(cfg),
        .ref_clk_mhz_in(rf), .ref_valid_in(rv), .try_fail_in(tf), .try_ok_in(tk),
        .boundary_scan_identity_out(id), .rom_at_zero_out(rom), .fetch_addr_out(adr),
        .static_timing_default_out(tmg), .processor_clock_mhz_out(pmhz), .master_clock_mhz_out(mmhz),
        .usb_monitor_en_out(usb), .src_enable_out(en), .src_try_out(tr), .src_active_out(act));
    bsi_boot_partner bsi_boot_partner_i (.clk_in(clk), .active_in(act), .fail_req_in(fr),
        .ok_req_in(kr), .try_fail_out(tf), .try_ok_out(tk));
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task stop_test;
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task rst_boot(input logic s);
        @(negedge clk);
        sel = s;
        rst = 1;
        repeat (16) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
    endtask : rst_boot
    task walk(input logic [2:0] v);
        logic [2:0] i;
        cfg = {5'h1A, v};
        rst_boot(1);
        i = 0;
        while (!MK[v][i]) i++;
        chk(act, 1);
        chk(tr, i);
        while (i != 3'h5) begin
            fr = 1;
            @(negedge clk);
            fr = 0;
            @(negedge clk);
            i++;
            while (!MK[v][i]) i++;
            chk(tr, i);
        end
        kr = 1;
        @(negedge clk);
        kr = 0;
        repeat (2) @(negedge clk);
        chk(act, 0);
    endtask : walk
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            stop_test;
        end
    end
    initial begin
        cfg = 8'hF8;
        rst_boot(1);
        chk(id, ID);
        chk(adr, 0);
        chk(rom, 1);
        chk(tmg, 0);
        chk(pmhz, 8'h60);
        chk(mmhz, 8'h30);
        chk(act, 1);
        sel = 0;
        repeat (3) @(negedge clk);
        chk(rom, 1);
        kr = 1;
        @(negedge clk);
        kr = 0;
        @(negedge clk);
        chk(act, 0);
        foreach (MK[v]) begin
            cfg = {5'h15, 3'(v)};
            repeat (2) @(negedge clk);
            chk(en, MK[v]);
        end
        for (int k = 0; k < 4; k++) begin
            rf = (k == 0) ? 8'h03 : (k == 1) ? 8'h04 : (k == 2) ? 8'h1C : 8'h1D;
            repeat (2) @(negedge clk);
            chk(pmhz, (k == 1 || k == 2) ? 8'h60 : 8'h0C);
            chk(usb, k == 1 || k == 2);
        end
        rf = 8'h0C;
        rv = 0;
        repeat (2) @(negedge clk);
        chk(mmhz, 8'h0C);
        rv = 1;
        rst_boot(0);
        chk(rom, 0);
        chk(tmg, 1);
        chk(pmhz, 8'h0C);
        chk(mmhz, 8'h0C);
        chk(usb, 0);
        chk(adr, 0);
        sel = 1;
        repeat (3) @(negedge clk);
        chk(rom, 0);
        walk(0);
        walk(1);
        walk(2);
        walk(4);
        walk(6);
        stop_test;
    end
endmodule : bsi_boot_select_bench
`default_nettype wire
